// [core/pelnd_pkg.sv]
// constants and carrier types of the interface event log and queued management block
// assumes one 100 MHz clock and a host-side command decoder feeding whole taskfiles
package pelnd_pkg;

  // log page geometry
  localparam logic [8:0]  PAGE_LAST     = 9'h1ff;
  localparam int          NUM_CNT       = 4;
  // counter identifiers: vendor bit, size code, event code
  localparam logic [15:0] CNT_ID [NUM_CNT] = '{16'h1001, 16'h1009, 16'h200a, 16'hc801};
  localparam int          CNT_IMPL_W [NUM_CNT] = '{8, 16, 32, 48};
  localparam logic [8:0]  CNT_OFF [NUM_CNT] = '{9'h004, 9'h008, 9'h00c, 9'h012};

  // management command
  localparam logic [7:0]  OPC_NCQ_ND    = 8'h63;
  localparam logic [3:0]  SUB_ABORT     = 4'h0;
  localparam logic [3:0]  SUB_DEADLINE  = 4'h1;
  localparam logic [3:0]  SUB_SETFEAT   = 4'h5;
  localparam logic [3:0]  ABT_ALL       = 4'h0;
  localparam logic [3:0]  ABT_STREAM    = 4'h1;
  localparam logic [3:0]  ABT_NONSTREAM = 4'h2;
  localparam logic [3:0]  ABT_SELECTED  = 4'h3;
  localparam logic [7:0]  STS_OK        = 8'h40;
  localparam logic [7:0]  STS_ERR       = 8'h41;
  localparam logic [7:0]  ERR_ABRT      = 8'h04;
  localparam logic [7:0]  ERR_NONE      = 8'h00;

  // register port
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_CNT_BASE  = 8'h10;
  localparam logic [31:0] CTRL_RESET    = 32'h001f_0f01;
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_MASK_LSB = 8;
  localparam int          CTRL_TAG_LSB  = 16;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [15:0] features;
    logic [15:0] count;
  } pelnd_cmd_t;

  typedef struct packed {
    logic        sdb;
    logic [7:0]  status;
    logic [7:0]  error;
    logic [31:0] act;
  } pelnd_resp_t;

  // bytes taken by a counter value, from size code bits 14:12
  function automatic logic [3:0] field_bytes(input logic [15:0] id);
    field_bytes = {id[14:12], 1'b0};
  endfunction

  // ones over the reported field of a counter
  function automatic logic [63:0] field_mask(input logic [15:0] id);
    field_mask = 64'hffff_ffff_ffff_ffff >> (7'd64 - {field_bytes(id), 3'b000});
  endfunction

endpackage

// [core/pelnd_core.sv]
// interface event counters, 512-byte log page streamer and queued management decoder
// assumes event pulses, taskfiles and queue state all come from logic on clk_i
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module pelnd_core (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  // register port
  input  wire logic [7:0]            reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic [31:0]                reg_rdata_o,
  // interface events, one pulse per event
  input  wire logic [3:0]            evt_i,
  // log page stream
  input  wire logic                  log_req_i,
  output logic                       log_valid_o,
  output logic [7:0]                 log_byte_o,
  output logic                       log_last_o,
  // management command from the taskfile decoder
  input  wire logic                  cmd_valid_i,
  input  wire pelnd_pkg::pelnd_cmd_t cmd_i,
  output logic                       cmd_ready_o,
  // queue state: accepted outstanding tags and their streaming flag
  input  wire logic [31:0]           outstanding_i,
  input  wire logic [31:0]           streaming_i,
  // completion report towards the link layer
  output logic                       resp_valid_o,
  output pelnd_pkg::pelnd_resp_t     resp_o,
  // tags the queue engine must drop
  output logic                       abort_valid_o,
  output logic [31:0]                abort_mask_o,
  // subcommands handed to the queue engine in order
  output logic                       fwd_valid_o,
  output pelnd_pkg::pelnd_cmd_t      fwd_o
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } pelnd_state_t;

  localparam int N = pelnd_pkg::NUM_CNT;

  logic [63:0]  cnt      [N];
  logic [63:0]  snap     [N];
  logic [63:0]  reported [N];
  logic [31:0]  ctrl;
  logic         log_busy;
  logic [8:0]   log_idx;
  logic [7:0]   log_sum;
  logic [7:0]   next_byte;
  pelnd_state_t state;
  pelnd_pkg::pelnd_cmd_t cur;
  logic [31:0]  acc_tags;
  logic [31:0]  acc_stream;
  logic [7:0]   last_status;
  logic [7:0]   last_error;
  logic [15:0]  done_count;
  logic [4:0]   own;
  logic [4:0]   ttag;
  logic [3:0]   atype;
  logic [31:0]  victims;

  logic         ncq_en;
  logic [3:0]   abt_support;
  logic [4:0]   max_tag;
  assign ncq_en      = ctrl[pelnd_pkg::CTRL_EN_BIT];
  assign abt_support = ctrl[pelnd_pkg::CTRL_MASK_LSB +: 4];
  assign max_tag     = ctrl[pelnd_pkg::CTRL_TAG_LSB +: 5];

  // implemented maximum of a counter
  function automatic logic [63:0] impl_max(input int k);
    impl_max = 64'hffff_ffff_ffff_ffff >> (64 - pelnd_pkg::CNT_IMPL_W[k]);
  endfunction

  // one bit per tag
  function automatic logic [31:0] tag_bit(input logic [4:0] t);
    tag_bit = 32'h0000_0001 << t;
  endfunction

  // event counters stop at their implemented maximum
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int k = 0; k < N; k++) begin
        cnt[k] <= 64'h0000_0000_0000_0000;
      end
    end else begin
      for (int k = 0; k < N; k++) begin
        if (evt_i[k] && cnt[k] != impl_max(k)) begin
          cnt[k] <= cnt[k] + 64'h0000_0000_0000_0001;
        end
      end
    end
  end

  // a saturated narrow counter is one-extended over its field
  always_comb begin
    for (int k = 0; k < N; k++) begin
      if (cnt[k] == impl_max(k)) begin
        reported[k] = pelnd_pkg::field_mask(pelnd_pkg::CNT_ID[k]);
      end else begin
        reported[k] = cnt[k] & pelnd_pkg::field_mask(pelnd_pkg::CNT_ID[k]);
      end
    end
  end

  // page byte at the current index, from the frozen snapshot
  always_comb begin
    logic [8:0] rel;
    logic [8:0] vlen;
    rel       = 9'h000;
    vlen      = 9'h000;
    next_byte = 8'h00;
    for (int k = 0; k < N; k++) begin
      rel  = log_idx - pelnd_pkg::CNT_OFF[k];
      vlen = {5'h00, pelnd_pkg::field_bytes(pelnd_pkg::CNT_ID[k])};
      if (log_idx >= pelnd_pkg::CNT_OFF[k]) begin
        if (rel == 9'h000) begin
          next_byte = pelnd_pkg::CNT_ID[k][7:0];
        end else if (rel == 9'h001) begin
          next_byte = pelnd_pkg::CNT_ID[k][15:8];
        end else if (rel < vlen + 9'h002) begin
          next_byte = snap[k][{rel[2:0] - 3'h2, 3'b000} +: 8];
        end
      end
    end
    // past the last record the terminator and tail stay zero up to the last byte, which carries the checksum
    if (log_idx == pelnd_pkg::PAGE_LAST) begin
      next_byte = 8'h00 - log_sum;
    end
  end

  // log page streamer: header, records, zero terminator, checksum
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      log_busy    <= 1'b0;
      log_idx     <= 9'h000;
      log_sum     <= 8'h00;
      log_valid_o <= 1'b0;
      log_byte_o  <= 8'h00;
      log_last_o  <= 1'b0;
    end else begin
      log_valid_o <= log_busy;
      log_byte_o  <= log_busy ? next_byte : 8'h00;
      log_last_o  <= log_busy && log_idx == pelnd_pkg::PAGE_LAST;
      if (log_busy) begin
        log_sum <= log_sum + next_byte;
        log_idx <= log_idx + 9'h001;
        if (log_idx == pelnd_pkg::PAGE_LAST) begin
          log_busy <= 1'b0;
        end
      end else if (log_req_i) begin
        log_busy <= 1'b1;
        log_idx  <= 9'h000;
        log_sum  <= 8'h00;
      end
    end
  end

  // snapshot keeps one page self-consistent while counters keep running
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int k = 0; k < N; k++) begin
        snap[k] <= 64'h0000_0000_0000_0000;
      end
    end else if (log_req_i && !log_busy) begin
      for (int k = 0; k < N; k++) begin
        snap[k] <= reported[k];
      end
    end
  end

  // fields of the held command and the tags an abort of that type drops
  always_comb begin
    own   = cur.count[7:3];
    ttag  = cur.features[12:8];
    atype = cur.features[7:4];
    // a tag that has completed meanwhile is not aborted twice
    case (atype)
      pelnd_pkg::ABT_ALL:       victims = acc_tags & outstanding_i;
      pelnd_pkg::ABT_STREAM:    victims = acc_tags & acc_stream & outstanding_i;
      pelnd_pkg::ABT_NONSTREAM: victims = acc_tags & ~acc_stream & outstanding_i;
      pelnd_pkg::ABT_SELECTED:  victims = acc_tags & tag_bit(ttag) & outstanding_i;
      default:                  victims = 32'h0000_0000;
    endcase
  end

  // command acceptance and execution
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state         <= ST_IDLE;
      cur           <= '0;
      acc_tags      <= 32'h0000_0000;
      acc_stream    <= 32'h0000_0000;
      cmd_ready_o   <= 1'b1;
      resp_valid_o  <= 1'b0;
      resp_o        <= '0;
      abort_valid_o <= 1'b0;
      abort_mask_o  <= 32'h0000_0000;
      fwd_valid_o   <= 1'b0;
      fwd_o         <= '0;
      last_status   <= pelnd_pkg::STS_OK;
      last_error    <= pelnd_pkg::ERR_NONE;
      done_count    <= 16'h0000;
    end else begin
      resp_valid_o  <= 1'b0;
      abort_valid_o <= 1'b0;
      fwd_valid_o   <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (cmd_valid_i && cmd_i.opcode == pelnd_pkg::OPC_NCQ_ND) begin
            cur         <= cmd_i;
            // only tags accepted before this command are candidates
            acc_tags    <= outstanding_i & ~tag_bit(cmd_i.count[7:3]);
            acc_stream  <= streaming_i;
            cmd_ready_o <= 1'b0;
            state       <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state       <= ST_IDLE;
          cmd_ready_o <= 1'b1;
          done_count  <= done_count + 16'h0001;
          if (!ncq_en) begin
            resp_valid_o <= 1'b1;
            resp_o       <= '{1'b0, pelnd_pkg::STS_ERR, pelnd_pkg::ERR_ABRT, 32'h0000_0000};
            last_status  <= pelnd_pkg::STS_ERR;
            last_error   <= pelnd_pkg::ERR_ABRT;
          end else if (cur.features[3:0] == pelnd_pkg::SUB_DEADLINE ||
                       cur.features[3:0] == pelnd_pkg::SUB_SETFEAT) begin
            fwd_valid_o <= 1'b1;
            fwd_o       <= cur;
          end else if (cur.features[3:0] != pelnd_pkg::SUB_ABORT) begin
            // reserved and unknown codes share one path
            resp_valid_o  <= 1'b1;
            resp_o        <= '{1'b0, pelnd_pkg::STS_ERR, pelnd_pkg::ERR_ABRT, 32'h0000_0000};
            abort_valid_o <= 1'b1;
            abort_mask_o  <= outstanding_i;
            last_status   <= pelnd_pkg::STS_ERR;
            last_error    <= pelnd_pkg::ERR_ABRT;
          end else if (ttag == own || ttag > max_tag || own > max_tag || atype > 4'h3 ||
                       !abt_support[atype[1:0]]) begin
            resp_valid_o <= 1'b1;
            resp_o       <= '{1'b0, pelnd_pkg::STS_ERR, pelnd_pkg::ERR_ABRT, 32'h0000_0000};
            last_status  <= pelnd_pkg::STS_ERR;
            last_error   <= pelnd_pkg::ERR_ABRT;
          end else begin
            // immediate: runs here, never waits behind queued work
            abort_valid_o <= 1'b1;
            abort_mask_o  <= victims;
            resp_valid_o  <= 1'b1;
            resp_o        <= '{1'b1, pelnd_pkg::STS_OK, pelnd_pkg::ERR_NONE,
                               victims | tag_bit(own)};
            last_status   <= pelnd_pkg::STS_OK;
            last_error    <= pelnd_pkg::ERR_NONE;
          end
        end
        default: begin
          state       <= ST_IDLE;
          cmd_ready_o <= 1'b1;
        end
      endcase
    end
  end

  // control register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl <= pelnd_pkg::CTRL_RESET;
    end else if (reg_wr_i && reg_addr_i == pelnd_pkg::REG_CTRL) begin
      ctrl <= reg_wdata_i & 32'h001f_0f01; // unused bits stay zero
    end
  end

  // read data stands one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_addr_i == pelnd_pkg::REG_CTRL) begin
      reg_rdata_o <= ctrl;
    end else if (reg_addr_i == pelnd_pkg::REG_STATUS) begin
      reg_rdata_o <= {done_count, last_error, last_status[7:2], log_busy, state[1]};
    end else if (reg_addr_i >= pelnd_pkg::REG_CNT_BASE &&
                 reg_addr_i < pelnd_pkg::REG_CNT_BASE + 8'h10 && reg_addr_i[1:0] == 2'b00) begin
      reg_rdata_o <= reported[reg_addr_i[3:2]][31:0];
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule

// [tb/pelnd_assertions.sv]
// pin-level checks of the event log streamer and queued management decoder
// assumes one clock domain and the core's reset value of the control register
`timescale 1ns/1ps
module pelnd_assertions (
  input wire logic                   clk_i,
  input wire logic                   resetn_i,
  input wire logic [7:0]             reg_addr_i,
  input wire logic [31:0]            reg_wdata_i,
  input wire logic                   reg_wr_i,
  input wire logic                   reg_rd_i,
  input wire logic [31:0]            reg_rdata_o,
  input wire logic                   log_valid_o,
  input wire logic [7:0]             log_byte_o,
  input wire logic                   log_last_o,
  input wire logic                   cmd_valid_i,
  input wire pelnd_pkg::pelnd_cmd_t  cmd_i,
  input wire logic                   cmd_ready_o,
  input wire logic                   resp_valid_o,
  input wire pelnd_pkg::pelnd_resp_t resp_o,
  input wire logic                   abort_valid_o,
  input wire logic                   fwd_valid_o,
  input wire pelnd_pkg::pelnd_cmd_t  fwd_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [8:0] idx;
  logic [7:0] sum;
  logic       ncq_en;
  logic       take;
  logic [3:0] sub;
  assign take = cmd_valid_i && cmd_ready_o && cmd_i.opcode == pelnd_pkg::OPC_NCQ_ND;
  assign sub  = cmd_i.features[3:0];
  // byte index and running sum, restarted after each page end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idx <= '0;
      sum <= '0;
    end else if (!log_valid_o || log_last_o) begin
      idx <= '0;
      sum <= '0;
    end else begin
      idx <= idx + 9'h001;
      sum <= sum + log_byte_o;
    end
  end
  // shadow of queuing enable, since every reject depends on it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) ncq_en <= 1'b1;
    else if (reg_wr_i && reg_addr_i == pelnd_pkg::REG_CTRL) ncq_en <= reg_wdata_i[0];
  end
  sequence s_busy;
    ##1 !cmd_ready_o;
  endsequence
  sequence s_reply;
    ##1 (resp_valid_o || fwd_valid_o);
  endsequence
  a_cmd_walk: assert property (take |-> s_busy ##0 s_reply)
    else $error("command reply late or missing");
  a_self_tag: assert property (take && ncq_en && sub == 4'h0 &&
    cmd_i.features[12:8] == cmd_i.count[7:3] |-> ##2 resp_valid_o && !resp_o.sdb &&
    resp_o.status == pelnd_pkg::STS_ERR && resp_o.error == pelnd_pkg::ERR_ABRT)
    else $error("own target tag not rejected");
  a_bad_sub: assert property (take && ncq_en && sub inside {[2:4], [6:15]}
    |-> ##2 abort_valid_o && resp_valid_o && resp_o.error == pelnd_pkg::ERR_ABRT)
    else $error("invalid subcommand not rejected");
  a_ncq_off: assert property (take && !ncq_en |-> ##2 resp_valid_o && !abort_valid_o
    && resp_o.status == pelnd_pkg::STS_ERR && resp_o.error == pelnd_pkg::ERR_ABRT)
    else $error("command taken with queuing off");
  a_fwd_sub: assert property (take && ncq_en && (sub == 4'h1 || sub == 4'h5)
    |-> ##2 fwd_valid_o && !resp_valid_o && fwd_o == $past(cmd_i, 2))
    else $error("queued subcommand not forwarded");
  a_good_sdb: assert property (resp_valid_o && resp_o.sdb |->
    resp_o.status == pelnd_pkg::STS_OK && resp_o.error == pelnd_pkg::ERR_NONE &&
    resp_o.act[$past(cmd_i.count[7:3], 2)])
    else $error("success report malformed");
  a_rd_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data outside its cycle");
  a_page_len: assert property (log_valid_o |-> log_last_o == (idx == 9'h1ff))
    else $error("page not 512 bytes");
  a_head_zero: assert property (log_valid_o && idx < 9'h004 |-> log_byte_o == 8'h00)
    else $error("header byte not zero");
  a_tail_zero: assert property (log_valid_o && idx >= 9'h01c && idx < 9'h1ff
    |-> log_byte_o == 8'h00)
    else $error("byte after terminator not zero");
  a_check_sum: assert property (log_last_o |-> 8'(sum + log_byte_o) == 8'h00)
    else $error("page checksum wrong");
endmodule
bind pelnd_core pelnd_assertions chk (.clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .log_valid_o, .log_byte_o, .log_last_o, .cmd_valid_i, .cmd_i,
  .cmd_ready_o, .resp_valid_o, .resp_o, .abort_valid_o, .fwd_valid_o, .fwd_o);

// [tb/pelnd_host_model.sv]
// host-side queue model: outstanding and streaming tag sets
// assumes the bench loads a tag set and the core names the tags it drops
`timescale 1ns/1ps
module pelnd_host_model (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        load_i,
  input  wire logic [31:0] tags_i,
  input  wire logic [31:0] strm_i,
  input  wire logic        abort_valid_i,
  input  wire logic [31:0] abort_mask_i,
  output logic      [31:0] outstanding_o,
  output logic      [31:0] streaming_o
);
  // dropped tags leave the queue; a fresh load wins over a drop
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      outstanding_o <= '0;
      streaming_o   <= '0;
    end else if (load_i) begin
      outstanding_o <= tags_i;
      streaming_o   <= strm_i;
    end else if (abort_valid_i) begin
      outstanding_o <= outstanding_o & ~abort_mask_i;
      streaming_o   <= streaming_o & ~abort_mask_i;
    end
  end
endmodule

// [tb/phy_event_log_and_ncq_nondata_test.sv]
// self-checking bench for the event log page and queued management core
// assumes the core, its checker and the host queue model; one 100 MHz clock
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module phy_event_log_and_ncq_nondata_test;
  localparam logic [15:0] REJ = {pelnd_pkg::STS_ERR, pelnd_pkg::ERR_ABRT};
  localparam logic [7:0]  OPC = pelnd_pkg::OPC_NCQ_ND;
  logic        clk_i, resetn_i, reg_wr_i, reg_rd_i, log_req_i, cmd_valid_i, load, rv, av, fv;
  logic        log_valid_o, log_last_o, cmd_ready_o, resp_valid_o, abort_valid_o, fwd_valid_o;
  logic [3:0]  evt_i;
  logic [7:0]  reg_addr_i, log_byte_o, s8;
  logic [31:0] reg_wdata_i, reg_rdata_o, abort_mask_o, outstanding, streaming, tags, strm;
  logic [7:0]  pg [512];
  logic [7:0]  ex [512];
  logic [63:0] vals [4];
  int          n_errors, samples_checked, o;
  int          cyc = 0;
  pelnd_pkg::pelnd_cmd_t  cmd_i, fwd_o;
  pelnd_pkg::pelnd_resp_t resp_o;
  pelnd_core uut (.clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .evt_i, .log_req_i, .log_valid_o, .log_byte_o, .log_last_o, .cmd_valid_i,
    .cmd_i, .cmd_ready_o, .outstanding_i(outstanding), .streaming_i(streaming), .resp_valid_o,
    .resp_o, .abort_valid_o, .abort_mask_o, .fwd_valid_o, .fwd_o);
  pelnd_host_model host (.clk_i, .resetn_i, .load_i(load), .tags_i(tags), .strm_i(strm),
    .abort_valid_i(abort_valid_o), .abort_mask_i(abort_mask_o), .outstanding_o(outstanding),
    .streaming_o(streaming));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // cut a hang short; the whole run needs under 2000 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rdx(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 `CHK(reg_rdata_o, e)
  endtask
  task automatic ev(input logic [3:0] m, input int n);
    @(posedge clk_i);
    evt_i <= m;
    repeat (n) @(posedge clk_i);
    evt_i <= 4'h0;
  endtask
  task automatic ld(input logic [31:0] t, input logic [31:0] s);
    @(posedge clk_i);
    {load, tags, strm} <= {1'b1, t, s};
    @(posedge clk_i);
    load <= 1'b0;
  endtask
  // one command, then a bounded wait for its reply pulse
  task automatic cmd(input logic [7:0] op, input logic [4:0] tg, input logic [3:0] sb, ty,
                     input logic [4:0] tt);
    @(posedge clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= '{op, {3'b000, tt, ty, sb}, {8'h00, tg, 3'b000}};
    @(posedge clk_i);
    cmd_valid_i <= 1'b0;
    {rv, av, fv} = 3'b000;
    for (int i = 0; i < 6 && !(rv || fv); i++) begin
      @(posedge clk_i);
      #1 {rv, av, fv} = {resp_valid_o, abort_valid_o, fwd_valid_o};
    end
  endtask
  task automatic ab(input logic [4:0] tg, tt, input logic [3:0] ty, input logic ok,
                    input logic [31:0] act);
    cmd(OPC, tg, pelnd_pkg::SUB_ABORT, ty, tt);
    `CHK({rv, resp_o.sdb, resp_o.status, resp_o.error},
      ok ? {2'b11, pelnd_pkg::STS_OK, pelnd_pkg::ERR_NONE} : {2'b10, REJ})
    if (ok) `CHK(resp_o.act, act)
  endtask
  task automatic page();
    int p;
    @(posedge clk_i);
    log_req_i <= 1'b1;
    @(posedge clk_i);
    log_req_i <= 1'b0;
    for (int i = 0; i < 8 && !log_valid_o; i++) @(posedge clk_i) #1;
    for (int b = 0; b < 512; b++) begin
      pg[b] = log_byte_o;
      `CHK({log_valid_o, log_last_o, log_byte_o},
        {1'b1, b == 511, ex[b]})
      @(posedge clk_i) #1;
    end
    `CHK(log_valid_o, 1'b0)
    p = 4;
    while (p < 511 && {pg[p + 1], pg[p]} != 16'h0000) p = p + 2 + 2 * pg[p + 1][6:4];
    `CHK(p, 28)
  endtask
  initial begin
    {reg_wr_i, reg_rd_i, log_req_i, cmd_valid_i, load, evt_i} = '0;
    {reg_addr_i, reg_wdata_i, tags, strm, cmd_i} = '0;
    n_errors = 0;
    samples_checked = 0;
    resetn_i = 1'b0;
    repeat (3) @(posedge clk_i);
    resetn_i <= 1'b1;
    rdx(pelnd_pkg::REG_CTRL, pelnd_pkg::CTRL_RESET);
    rdx(8'h08, 32'h0000_0000);
    ev(4'hb, 2);
    ev(4'h3, 3);
    ev(4'h1, 295);
    rdx(8'h10, 32'h0000_ffff);
    rdx(8'h14, 32'h0000_0005);
    rdx(8'h1c, 32'h0000_0002);
    // expected page: records at their offsets, zeros elsewhere, checksum last
    vals = '{64'h0000_0000_0000_ffff, 64'h0000_0000_0000_0005, '0, 64'h0000_0000_0000_0002};
    ex = '{default: 8'h00};
    s8 = 8'h00;
    for (int k = 0; k < pelnd_pkg::NUM_CNT; k++) begin
      o = int'(pelnd_pkg::CNT_OFF[k]);
      {ex[o + 1], ex[o]} = pelnd_pkg::CNT_ID[k];
      for (int j = 0; j < 2 * pelnd_pkg::CNT_ID[k][14:12]; j++) begin
        ex[o + 2 + j] = vals[k][8 * j +: 8];
      end
    end
    for (int b = 0; b < 511; b++) s8 = s8 + ex[b];
    ex[511] = 8'h00 - s8;
    page();
    ld(32'h0000_000e, 32'h0000_0004);
    ab(5'h05, 5'h00, 4'h1, 1'b1, 32'h0000_0024);
    ab(5'h05, 5'h00, 4'h2, 1'b1, 32'h0000_002a);
    ab(5'h00, 5'h01, 4'h0, 1'b1, 32'h0000_0001);
    ld(32'h0000_0018, 32'h0000_0000);
    ab(5'h04, 5'h03, 4'h3, 1'b1, 32'h0000_0018);
    ab(5'h06, 5'h06, 4'h0, 1'b0, 32'h0000_0000);
    ab(5'h06, 5'h01, 4'h4, 1'b0, 32'h0000_0000);
    wr(pelnd_pkg::REG_CTRL, 32'h000f_0701);
    ab(5'h02, 5'h14, 4'h0, 1'b0, 32'h0000_0000);
    ab(5'h02, 5'h01, 4'h3, 1'b0, 32'h0000_0000);
    ab(5'h02, 5'h01, 4'h0, 1'b1, 32'h0000_0014);
    for (int s = 2; s < 16; s++) begin
      if (s == 5) continue;
      ld(32'h0000_0300, 32'h0000_0000);
      cmd(OPC, 5'h01, 4'(s), 4'h0, 5'h00);
      `CHK({rv, av, abort_mask_o, resp_o.status, resp_o.error},
        {2'b11, 32'h0000_0300, REJ})
    end
    for (int s = 1; s < 6; s += 4) begin
      cmd(OPC, 5'h03, 4'(s), 4'h0, 5'h00);
      `CHK({fv, rv, fwd_o}, {2'b10, cmd_i})
    end
    wr(pelnd_pkg::REG_CTRL, 32'h000f_0700);
    cmd(OPC, 5'h01, 4'h0, 4'h0, 5'h02);
    `CHK({rv, av, resp_o.status, resp_o.error}, {2'b10, REJ})
    cmd(8'h60, 5'h01, 4'h0, 4'h0, 5'h02);
    `CHK({rv, fv}, 2'b00)
    // 25 executed commands, last one the queuing-off reject, the foreign opcode not counted
    rdx(pelnd_pkg::REG_STATUS, 32'h0019_0440);
    conclude();
  end
endmodule
